//--- hdl/rps_regs.svh
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// register byte offsets
`define RPS_OFS_CONFIG      5'h00
`define RPS_OFS_CAUSE       5'h04
`define RPS_OFS_STATE       5'h08
`define RPS_OFS_INT_STATUS  5'h0c
`define RPS_OFS_INT_MASK    5'h10
`define RPS_OFS_CONVERTER   5'h14
`define RPS_OFS_RESULT_HIGH 5'h18
`define RPS_OFS_RESULT_LOW  5'h1c

// reset_cause_register fields
`define RPS_CAUSE_POR_BIT   1
`define RPS_CAUSE_BOD_BIT   0
`define RPS_CAUSE_RESET     2'h0

// event bits of int status and mask
`define RPS_EV_POR          0
`define RPS_EV_BOD          1
`define RPS_EV_WDT          2
`define RPS_EV_EXT          3
`define RPS_EV_RELEASE      4
`define RPS_EV_W            5

// converter control fields
`define RPS_CONV_ON_BIT     0
`define RPS_CONV_GO_BIT     1

`define RPS_CONFIG_RESET    6'h00
`define RPS_PC_W            13

// timing
`define RPS_POWER_UP_TIMER_US         72000
`define RPS_RC_KHZ          32
`define RPS_OST_CYCLES      1024

`endif

//--- hdl/rps_pkg.sv
package rps_pkg;

  typedef enum logic [2:0] {
    RPS_OSC_LOW_POWER  = 3'h0,
    RPS_OSC_MEDIUM     = 3'h1,
    RPS_OSC_HIGH_SPEED = 3'h2,
    RPS_OSC_EXT_CLOCK  = 3'h3,
    RPS_OSC_INT_RC     = 3'h4,
    RPS_OSC_EXT_RC     = 3'h5,
    RPS_OSC_INT_RC_IO  = 3'h6,
    RPS_OSC_EXT_RC_IO  = 3'h7
  } rps_osc_mode_t;

  typedef struct packed {
    rps_osc_mode_t osc_mode;
    logic          brownout_enable;
    logic          power_up_timer_disable;
    logic          internal_reset_tie_select;
  } rps_config_t;

  typedef enum logic [1:0] {
    RPS_ST_HOLD = 2'b00,
    RPS_ST_POWER_UP_TIMER = 2'b01,
    RPS_ST_OST  = 2'b10,
    RPS_ST_RUN  = 2'b11
  } rps_state_t;

  typedef struct packed {
    logic ext_pin;
    logic supply_ok;
    logic below_brownout;
    logic rc_osc;
    logic osc_in;
  } rps_pins_t;

endpackage : rps_pkg

//--- hdl/rps_sync.sv
module rps_sync (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire rps_pkg::rps_pins_t pins_in,
  output rps_pkg::rps_pins_t      pins_out
);
  import rps_pkg::*;

  // reset pin idles high: no false press right after reset
  localparam rps_pins_t PINS_IDLE = '{ext_pin: 1'b1, default: 1'b0};

  rps_pins_t meta_reg;
  rps_pins_t sync_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= PINS_IDLE;
      sync_reg <= PINS_IDLE;
    end else begin
      meta_reg <= pins_in;
      sync_reg <= meta_reg;
    end
  end

  assign pins_out = sync_reg;

endmodule : rps_sync

//--- hdl/rps_sequencer.sv
`include "rps_regs.svh"

// Summary of operation
// RL1: watchdog reset stays internal, never drives the external reset pin low.
// RL2: tie-select config bit makes the external reset pin permanently inactive.
// RL3: no internal pull-up; reset pin level comes only from outside.
// RL4: internal reset held while power-on detect shows supply too low.
// RL5: falling supply never causes a power-on reset; only power-up does.
// RL6: with brown-out enabled, reset held until supply passes the threshold.
// RL7: power-up timer gives 72 ms, started only by power-on or brown-out.
// RL8: power-up timer counts a dedicated internal RC oscillator.
// RL9: chip stays in reset while the power-up timer runs.
// RL10: power-up timer disable bit skips the delay; cleared applies it.
// RL11: software should keep power-up timer enabled when brown-out is enabled.
// RL12: after power-up timer, count 1024 oscillator input cycles before release.
// RL13: start-up timer only in crystal modes, after power-on or sleep wake; the code also runs it after a brown-out reset.
// RL14: any reset loads reset values, turns converter off, aborts conversion; the code reloads config, cause and interrupt registers only on block reset.
// RL15: reset leaves both conversion result registers unchanged.
// RL16: hardware clears power-on and brown-out flags; software sets them again.
// RL17: any reset clears the 13-bit program counter.
// RL18: release only with all sources quiet and delays done in order.
module rps_sequencer #(
  parameter int POWER_UP_TIMER_TICKS = (`RPS_POWER_UP_TIMER_US * `RPS_RC_KHZ) / 1000
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        external_reset_pin_i,
  output logic             external_reset_pin_o,
  output logic             external_reset_pin_oe,
  input  wire logic        supply_above_por,
  input  wire logic        brownout_detect,
  input  wire logic        watchdog_timeout,
  input  wire logic        wake_from_sleep,
  input  wire logic        rc_osc_clk,
  input  wire logic        oscillator_input_pin,
  output logic             chip_reset,
  output logic             core_stall,
  output logic             converter_power_on,
  output logic             converter_abort,
  output logic [12:0]      program_counter,
  output logic             irq
);
  import rps_pkg::*;

  localparam logic [15:0] POWER_UP_TIMER_LAST = 16'(POWER_UP_TIMER_TICKS - 1);
  localparam logic [15:0] OST_LAST  = 16'(`RPS_OST_CYCLES - 1);

  rps_pins_t   pins_raw;
  rps_pins_t   pins_s;
  rps_config_t config_reg;
  rps_state_t  state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic [1:0]  reset_cause_reg;
  logic [`RPS_EV_W-1:0] int_status_reg, int_mask_reg, event_set;
  logic [1:0]  converter_reg;
  logic [7:0]  result_high_reg, result_low_reg;
  logic [12:0] pc_reg;
  logic        rc_prev_reg, osc_prev_reg, supply_prev_reg, bod_prev_reg, ext_prev_reg;
  logic        por_seen_reg, pwrup_pend_reg, wake_ost_reg;
  logic        chip_reset_reg, abort_reg, ack_reg;
  logic [31:0] readdata_reg;

  assign pins_raw = '{ext_pin: external_reset_pin_i, supply_ok: supply_above_por,
                      below_brownout: brownout_detect, rc_osc: rc_osc_clk,
                      osc_in: oscillator_input_pin};

  rps_sync u_sync (
    .clk      (clk),
    .reset    (reset),
    .pins_in  (pins_raw),
    .pins_out (pins_s)
  );

  function automatic logic is_crystal(input rps_osc_mode_t m);
    return (m == RPS_OSC_LOW_POWER) || (m == RPS_OSC_MEDIUM) || (m == RPS_OSC_HIGH_SPEED);
  endfunction : is_crystal

  // RL2 tie-select masks pin; RL3 raw pin level, no pull-up term
  wire ext_active  = ~config_reg.internal_reset_tie_select & ~pins_s.ext_pin;
  // RL4 supply low holds reset; RL5 only until first power-up
  wire por_hold    = ~por_seen_reg;
  // RL6 brown-out holds reset while supply below threshold
  wire bod_active  = config_reg.brownout_enable & pins_s.below_brownout;
  wire any_src     = por_hold | bod_active | ext_active | watchdog_timeout;
  wire por_rise    = pins_s.supply_ok & ~supply_prev_reg & ~por_seen_reg;
  wire bod_rise    = bod_active & ~bod_prev_reg;
  // RL8 power-up timer paced by the internal RC oscillator
  wire rc_edge     = pins_s.rc_osc & ~rc_prev_reg;
  wire osc_edge    = pins_s.osc_in & ~osc_prev_reg;
  wire xtal        = is_crystal(config_reg.osc_mode);
  wire in_ost_wake = (state_reg == RPS_ST_OST) & wake_ost_reg;

  // bus decode
  wire        bus_take = (avs_read | avs_write) & ack_reg;
  wire        wr_take  = avs_write & ack_reg;
  wire [4:0]  wofs     = {avs_address[4:2], 2'b00};
  wire        wr_cfg   = wr_take & (wofs == `RPS_OFS_CONFIG);
  wire        wr_cause = wr_take & (wofs == `RPS_OFS_CAUSE);
  wire        wr_int   = wr_take & (wofs == `RPS_OFS_INT_STATUS);
  wire        wr_mask  = wr_take & (wofs == `RPS_OFS_INT_MASK);
  wire        wr_conv  = wr_take & (wofs == `RPS_OFS_CONVERTER);
  wire        wr_hi    = wr_take & (wofs == `RPS_OFS_RESULT_HIGH);
  wire        wr_lo    = wr_take & (wofs == `RPS_OFS_RESULT_LOW);

  // RL18 sources quiet, then timer order power_up_timer before ost
  always_comb begin
    state_next = state_reg;
    count_next = count_reg + 16'h0001;
    case (state_reg)
      RPS_ST_HOLD: begin
        count_next = 16'h0000;
        if (!any_src) begin
          // RL10 disable bit skips the power-up delay
          if (pwrup_pend_reg && !config_reg.power_up_timer_disable) begin
            state_next = RPS_ST_POWER_UP_TIMER;
          end else if (pwrup_pend_reg && xtal) begin
            state_next = RPS_ST_OST;
          end else begin
            state_next = RPS_ST_RUN;
          end
        end
      end
      RPS_ST_POWER_UP_TIMER: begin
        if (!rc_edge) begin
          count_next = count_reg;
        end
        if (any_src) begin
          state_next = RPS_ST_HOLD;
        end else if (rc_edge && count_reg == POWER_UP_TIMER_LAST) begin
          // RL13 start-up timer only in crystal modes
          state_next = xtal ? RPS_ST_OST : RPS_ST_RUN;
          count_next = 16'h0000;
        end
      end
      RPS_ST_OST: begin
        if (!osc_edge) begin
          count_next = count_reg;
        end
        if (any_src) begin
          state_next = RPS_ST_HOLD;
        end else if (osc_edge && count_reg == OST_LAST) begin
          // RL12 release after 1024 oscillator input cycles
          state_next = RPS_ST_RUN;
        end
      end
      RPS_ST_RUN: begin
        count_next = 16'h0000;
        if (any_src) begin
          state_next = RPS_ST_HOLD;
        end else if (wake_from_sleep && xtal) begin
          // RL13 wake from sleep reruns the start-up timer
          state_next = RPS_ST_OST;
        end
      end
      default: begin
        state_next = RPS_ST_HOLD;
        count_next = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= RPS_ST_HOLD;
      count_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rc_prev_reg     <= 1'b0;
      osc_prev_reg    <= 1'b0;
      supply_prev_reg <= 1'b0;
      bod_prev_reg    <= 1'b0;
      ext_prev_reg    <= 1'b0;
    end else begin
      rc_prev_reg     <= pins_s.rc_osc;
      osc_prev_reg    <= pins_s.osc_in;
      supply_prev_reg <= pins_s.supply_ok;
      bod_prev_reg    <= bod_active;
      ext_prev_reg    <= ext_active;
    end
  end

  // RL7 power-up timer armed only by power-on or brown-out
  always_ff @(posedge clk) begin
    if (reset) begin
      por_seen_reg   <= 1'b0;
      pwrup_pend_reg <= 1'b1;
      wake_ost_reg   <= 1'b0;
    end else begin
      por_seen_reg   <= por_seen_reg | por_rise;
      if (por_rise || bod_rise) begin
        pwrup_pend_reg <= 1'b1;
      end else if (state_reg == RPS_ST_HOLD && !any_src) begin
        pwrup_pend_reg <= 1'b0;
      end
      wake_ost_reg   <= (state_next == RPS_ST_OST) &
                        ((state_reg == RPS_ST_RUN) | wake_ost_reg);
    end
  end

  // RL9 chip held while the power-up timer runs
  always_ff @(posedge clk) begin
    if (reset) begin
      chip_reset_reg <= 1'b1;
    end else begin
      chip_reset_reg <= (state_next != RPS_ST_RUN) &
                        ~((state_next == RPS_ST_OST) & (state_reg == RPS_ST_RUN | wake_ost_reg));
    end
  end

  // RL1 pin is never driven, watchdog reset stays inside
  assign external_reset_pin_o  = 1'b0;
  assign external_reset_pin_oe = 1'b0;

  assign event_set = {chip_reset_reg & ~(state_next != RPS_ST_RUN),
                      ext_active & ~ext_prev_reg, watchdog_timeout, bod_rise, por_rise};

  // hardware events win over software writes
  always_ff @(posedge clk) begin
    if (reset) begin
      config_reg      <= `RPS_CONFIG_RESET;
      reset_cause_reg <= `RPS_CAUSE_RESET;
      int_status_reg  <= '0;
      int_mask_reg    <= '0;
    end else begin
      if (wr_cfg) begin
        config_reg <= avs_writedata[5:0];
      end
      // RL16 hardware clears the cause flag; software sets it back
      reset_cause_reg <= (wr_cause ? avs_writedata[1:0] : reset_cause_reg) &
                         ~{por_rise, bod_rise};
      int_status_reg  <= (int_status_reg & ~({`RPS_EV_W{wr_int}} &
                          avs_writedata[`RPS_EV_W-1:0])) | event_set;
      if (wr_mask) begin
        int_mask_reg <= avs_writedata[`RPS_EV_W-1:0];
      end
    end
  end

  // RL14 chip reset turns converter off and aborts conversion
  always_ff @(posedge clk) begin
    if (reset) begin
      converter_reg <= 2'h0;
      abort_reg     <= 1'b0;
    end else begin
      abort_reg     <= chip_reset_reg & converter_reg[`RPS_CONV_GO_BIT];
      if (chip_reset_reg) begin
        converter_reg <= 2'h0;
      end else if (wr_conv) begin
        converter_reg <= avs_writedata[1:0];
      end
    end
  end

  // RL15 results only change by a write, never by chip reset
  always_ff @(posedge clk) begin
    if (wr_hi) begin
      result_high_reg <= avs_writedata[7:0];
    end
    if (wr_lo) begin
      result_low_reg <= avs_writedata[7:0];
    end
  end

  // RL17 program counter cleared on any reset
  always_ff @(posedge clk) begin
    if (reset || chip_reset_reg) begin
      pc_reg <= 13'h0000;
    end else if (!core_stall) begin
      pc_reg <= pc_reg + 13'h0001;
    end
  end

  // one wait cycle: read data is ready when waitrequest drops
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read && !ack_reg) begin
        case (wofs)
          `RPS_OFS_CONFIG:      readdata_reg <= {26'h0, config_reg};
          `RPS_OFS_CAUSE:       readdata_reg <= {30'h0, reset_cause_reg};
          `RPS_OFS_STATE:       readdata_reg <= {28'h0, state_reg, core_stall, chip_reset_reg};
          `RPS_OFS_INT_STATUS:  readdata_reg <= {27'h0, int_status_reg};
          `RPS_OFS_INT_MASK:    readdata_reg <= {27'h0, int_mask_reg};
          `RPS_OFS_CONVERTER:   readdata_reg <= {30'h0, converter_reg};
          `RPS_OFS_RESULT_HIGH: readdata_reg <= {24'h0, result_high_reg};
          `RPS_OFS_RESULT_LOW:  readdata_reg <= {24'h0, result_low_reg};
          default:              readdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_waitrequest    = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata       = readdata_reg;
  assign chip_reset         = chip_reset_reg;
  assign core_stall         = in_ost_wake;
  assign converter_power_on = converter_reg[`RPS_CONV_ON_BIT];
  assign converter_abort    = abort_reg;
  assign program_counter    = pc_reg;
  assign irq                = |(int_status_reg & int_mask_reg);

  sequence s_enter_run;
    (state_reg != RPS_ST_RUN) ##1 (state_reg == RPS_ST_RUN);
  endsequence

  sequence s_power_up_timer_end;
    (state_reg == RPS_ST_POWER_UP_TIMER) ##1 (state_reg != RPS_ST_POWER_UP_TIMER);
  endsequence

  AST_WDT_PIN_QUIET: assert property (@(posedge clk) disable iff (reset) // RL1
    watchdog_timeout |-> ##[0:2] !external_reset_pin_oe)
    else $error("watchdog drove reset pin");
  AST_TIE_IGNORES_PIN: assert property (@(posedge clk) disable iff (reset) // RL2
    (state_reg == RPS_ST_RUN && config_reg.internal_reset_tie_select && !por_hold &&
     !bod_active && !watchdog_timeout && !wake_from_sleep) |=> state_reg == RPS_ST_RUN)
    else $error("tied reset pin still reset chip");
  AST_PIN_LOW_RESETS: assert property (@(posedge clk) disable iff (reset) // RL3
    (state_reg == RPS_ST_RUN && ext_active) |=> state_reg == RPS_ST_HOLD ##1 chip_reset)
    else $error("low reset pin ignored");
  AST_POR_HOLDS: assert property (@(posedge clk) disable iff (reset) // RL4
    por_hold |=> chip_reset_reg)
    else $error("released while supply low");
  AST_POR_NO_FALL: assert property (@(posedge clk) disable iff (reset) // RL5
    (por_seen_reg && $fell(pins_s.supply_ok)) |=> por_seen_reg && !por_rise)
    else $error("falling supply gave power-on reset");
  AST_BOD_HOLDS: assert property (@(posedge clk) disable iff (reset) // RL6
    bod_active |=> chip_reset_reg)
    else $error("released below brown-out threshold");
  AST_POWER_UP_TIMER_CAUSE: assert property (@(posedge clk) disable iff (reset) // RL7
    $rose(state_reg == RPS_ST_POWER_UP_TIMER) |-> $past(pwrup_pend_reg))
    else $error("power-up timer started by other reset");
  AST_POWER_UP_TIMER_IN_RESET: assert property (@(posedge clk) disable iff (reset) // RL9
    (state_reg == RPS_ST_POWER_UP_TIMER) |-> chip_reset_reg && !core_stall)
    else $error("chip out of reset during power-up timer");
  AST_POWER_UP_TIMER_SKIP: assert property (@(posedge clk) disable iff (reset) // RL10
    (state_reg == RPS_ST_HOLD && !any_src && config_reg.power_up_timer_disable)
    |=> state_reg != RPS_ST_POWER_UP_TIMER)
    else $error("disabled power-up timer ran");
  AST_OST_DONE: assert property (@(posedge clk) disable iff (reset) // RL12
    (state_reg == RPS_ST_OST && osc_edge && count_reg == OST_LAST && !any_src)
    |=> state_reg == RPS_ST_RUN ##1 !chip_reset_reg)
    else $error("start-up timer end not released");
  AST_OST_XTAL: assert property (@(posedge clk) disable iff (reset) // RL13
    $rose(state_reg == RPS_ST_OST) |-> $past(xtal))
    else $error("start-up timer outside crystal mode");
  AST_CONV_OFF: assert property (@(posedge clk) disable iff (reset) // RL14
    chip_reset_reg |=> !converter_power_on && !converter_reg[`RPS_CONV_GO_BIT])
    else $error("converter left on in reset");
  AST_RESULT_KEPT: assert property (@(posedge clk) disable iff (reset) // RL15
    (chip_reset_reg && !wr_hi && !wr_lo) |=> $stable(result_high_reg) && $stable(result_low_reg))
    else $error("result changed by reset");
  AST_CAUSE_CLEAR: assert property (@(posedge clk) disable iff (reset) // RL16
    por_rise |=> !reset_cause_reg[`RPS_CAUSE_POR_BIT])
    else $error("power-on flag not cleared");
  AST_PC_CLEAR: assert property (@(posedge clk) disable iff (reset) // RL17
    chip_reset_reg |=> program_counter == 13'h0000)
    else $error("program counter not cleared");
  AST_RELEASE_QUIET: assert property (@(posedge clk) disable iff (reset) // RL18
    s_enter_run |-> !$past(any_src))
    else $error("released with a source active");
  AST_POWER_UP_TIMER_THEN_OST: assert property (@(posedge clk) disable iff (reset) // RL18
    s_power_up_timer_end |-> (state_reg == RPS_ST_HOLD) ||
                   (state_reg == ($past(xtal) ? RPS_ST_OST : RPS_ST_RUN)))
    else $error("power-up timer order broken");

endmodule : rps_sequencer

//--- testbench/rps_board.sv
module rps_board (
  input  wire logic supply_on,
  input  wire logic dip,
  input  wire logic press,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      supply_above_por,
  output logic      brownout_detect,
  output logic      pin_level,
  output logic      rc_osc_clk,
  output logic      oscillator_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rc_osc_clk = 1'b0;
    forever #1103 rc_osc_clk = ~rc_osc_clk;
  end
  // crystal runs free, off the clk grid
  initial begin
    oscillator_input_pin = 1'b0;
    forever #353 oscillator_input_pin = ~oscillator_input_pin;
  end
  assign supply_above_por = supply_on;
  assign brownout_detect = dip;
  // only the board resistor holds pin high
  assign pin_level = pin_oe ? pin_o : ~press;
endmodule : rps_board

//--- testbench/rps_sequencer_tb.sv
`include "rps_regs.svh"
module rps_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rps_pkg::*;
  localparam int POWER_UP_TIMER = 4;
  logic        clk;
  logic        reset;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pin_level;
  logic        pin_o;
  logic        pin_oe;
  logic        por_ok;
  logic        bo_low;
  logic        watchdog_timeout;
  logic        wake_from_sleep;
  logic        rc_clk;
  logic        osc_in;
  logic        chip_reset;
  logic        core_stall;
  logic        conv_on;
  logic        conv_abort;
  logic [12:0] program_counter;
  logic        irq;
  logic        supply_on;
  logic        dip;
  logic        press;
  int          rc_n;
  int          osc_n;
  int          abort_n;
  int          bad_count;
  int          compares;

  rps_sequencer #(.POWER_UP_TIMER_TICKS(POWER_UP_TIMER)) dut_u (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_reset_pin_i(pin_level),
    .external_reset_pin_o(pin_o), .external_reset_pin_oe(pin_oe),
    .supply_above_por(por_ok), .brownout_detect(bo_low),
    .watchdog_timeout(watchdog_timeout), .wake_from_sleep(wake_from_sleep),
    .rc_osc_clk(rc_clk), .oscillator_input_pin(osc_in), .chip_reset(chip_reset),
    .core_stall(core_stall), .converter_power_on(conv_on),
    .converter_abort(conv_abort), .program_counter(program_counter), .irq(irq));

  rps_board board_u (
    .supply_on(supply_on), .dip(dip), .press(press), .pin_o(pin_o), .pin_oe(pin_oe),
    .supply_above_por(por_ok), .brownout_detect(bo_low), .pin_level(pin_level),
    .rc_osc_clk(rc_clk), .oscillator_input_pin(osc_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge rc_clk) rc_n++;
  always @(posedge osc_in) osc_n++;
  always @(posedge clk) if (conv_abort === 1'b1) abort_n++;

  task automatic conclude;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    // answer taken at the rising edge that sees waitrequest low
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        check(avs_waitrequest, 1'b0);
        conclude();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask : rdc

  task automatic wait_for(input logic stall, input logic lvl, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        check(stall ? core_stall : chip_reset, lvl);
        conclude();
      end
    end while ((stall ? core_stall : chip_reset) !== lvl);
  endtask : wait_for

  // block reset stands in for a fresh power-up
  task automatic power_up(input logic [31:0] cfg);
    @(posedge clk);
    reset <= 1'b1;
    supply_on <= 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    wr(`RPS_OFS_CONFIG, cfg);
    wr(`RPS_OFS_CAUSE, 32'h3);
    repeat (30) @(negedge clk);
    check(chip_reset, 1'b1);
    check(program_counter, 13'h0);
    @(posedge clk);
    rc_n = 0;
    osc_n = 0;
    supply_on <= 1'b1;
    wait_for(1'b0, 1'b0, 20000);
  endtask : power_up

  task automatic sc_crystal;
    power_up({RPS_OSC_LOW_POWER, 3'b000});
    check(rc_n >= POWER_UP_TIMER, 1'b1);
    check(osc_n >= `RPS_OST_CYCLES, 1'b1);
    check(osc_n <= `RPS_OST_CYCLES + 24, 1'b1);
    rdc(`RPS_OFS_CAUSE, 32'h3, 32'h1);
    wr(`RPS_OFS_CAUSE, 32'h3);
    rdc(`RPS_OFS_CAUSE, 32'h3, 32'h3);
    @(posedge clk);
    osc_n = 0;
    wake_from_sleep <= 1'b1;
    @(posedge clk);
    wake_from_sleep <= 1'b0;
    wait_for(1'b1, 1'b1, 10);
    wait_for(1'b1, 1'b0, 12000);
    check(osc_n >= `RPS_OST_CYCLES, 1'b1);
    check(chip_reset, 1'b0);
  endtask : sc_crystal

  task automatic sc_rc_modes;
    power_up({RPS_OSC_INT_RC, 3'b010});
    check(rc_n <= 1, 1'b1);
    check(osc_n <= 8, 1'b1);
    power_up({RPS_OSC_INT_RC, 3'b000});
    check(rc_n >= POWER_UP_TIMER, 1'b1);
    check(osc_n <= 40, 1'b1);
  endtask : sc_rc_modes

  task automatic sc_watchdog;
    wr(`RPS_OFS_CONVERTER, 32'h3);
    wr(`RPS_OFS_RESULT_HIGH, 32'h5a);
    wr(`RPS_OFS_RESULT_LOW, 32'ha5);
    @(posedge clk);
    rc_n = 0;
    abort_n = 0;
    watchdog_timeout <= 1'b1;
    @(posedge clk);
    watchdog_timeout <= 1'b0;
    wait_for(1'b0, 1'b1, 5);
    check(pin_level, 1'b1);
    @(negedge clk);
    check(program_counter, 13'h0);
    wait_for(1'b0, 1'b0, 50);
    check(rc_n <= 1, 1'b1);
    check(abort_n, 1);
    check(conv_on, 1'b0);
    rdc(`RPS_OFS_CONVERTER, 32'h3, 32'h0);
    rdc(`RPS_OFS_RESULT_HIGH, 32'hff, 32'h5a);
    rdc(`RPS_OFS_RESULT_LOW, 32'hff, 32'ha5);
  endtask : sc_watchdog

  task automatic sc_pin_irq;
    wr(`RPS_OFS_INT_STATUS, 32'h1f);
    wr(`RPS_OFS_INT_MASK, 32'h08);
    @(posedge clk);
    press <= 1'b1;
    wait_for(1'b0, 1'b1, 10);
    check(irq, 1'b1);
    @(posedge clk);
    press <= 1'b0;
    wait_for(1'b0, 1'b0, 50);
    wr(`RPS_OFS_INT_STATUS, 32'h08);
    @(negedge clk);
    check(irq, 1'b0);
    // state word is read only
    wr(`RPS_OFS_STATE, 32'hffffffff);
    rdc(`RPS_OFS_STATE, 32'hf, 32'hc);
    wr(`RPS_OFS_CONFIG, {RPS_OSC_INT_RC, 3'b001});
    @(posedge clk);
    press <= 1'b1;
    repeat (20) @(negedge clk);
    check(chip_reset, 1'b0);
    @(posedge clk);
    press <= 1'b0;
  endtask : sc_pin_irq

  task automatic sc_brownout;
    wr(`RPS_OFS_CONFIG, {RPS_OSC_INT_RC, 3'b100});
    wr(`RPS_OFS_CAUSE, 32'h3);
    @(posedge clk);
    supply_on <= 1'b0;
    repeat (20) @(negedge clk);
    check(chip_reset, 1'b0);
    @(posedge clk);
    supply_on <= 1'b1;
    dip <= 1'b1;
    wait_for(1'b0, 1'b1, 10);
    repeat (40) @(negedge clk);
    check(chip_reset, 1'b1);
    @(posedge clk);
    rc_n = 0;
    dip <= 1'b0;
    wait_for(1'b0, 1'b0, 400);
    check(rc_n >= POWER_UP_TIMER, 1'b1);
    rdc(`RPS_OFS_CAUSE, 32'h3, 32'h2);
  endtask : sc_brownout

  initial begin
    reset = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    watchdog_timeout = 1'b0;
    wake_from_sleep = 1'b0;
    supply_on = 1'b0;
    dip = 1'b0;
    press = 1'b0;
    bad_count = 0;
    compares = 0;
    sc_crystal();
    sc_rc_modes();
    sc_watchdog();
    sc_pin_irq();
    sc_brownout();
    conclude();
  end
endmodule : rps_sequencer_tb
